// >>> ccs_host_model.sv
// partner: i2c controller model that reaches the charger register bank
`timescale 1ns/1ps
`default_nettype none
module ccs_host_model #(
	parameter int HALF = 6
) (
	// clock and bus
	input wire logic clock_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_low_o
);
	import ccs_pkg::*;
	// -----------------------------------------------------------
	// bit and byte level bus cycles
	// -----------------------------------------------------------
	logic [6:0] dev_addr = CCS_I2C_ADDR;
	initial begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
	end
	task automatic gap();
		repeat (HALF) @(negedge clock_i);
	endtask
	// start or repeated start, scl phases kept above the filter length
	task automatic start_cond();
		sda_low_o = 1'b0;
		gap();
		scl_o = 1'b1;
		gap();
		sda_low_o = 1'b1;
		gap();
		scl_o = 1'b0;
		gap();
	endtask
	task automatic stop_cond();
		sda_low_o = 1'b1;
		gap();
		scl_o = 1'b1;
		gap();
		sda_low_o = 1'b0;
		gap();
	endtask
	// data changes only while scl is low, sampled while high
	task automatic bit_io(input logic b, output logic r);
		sda_low_o = ~b;
		gap();
		scl_o = 1'b1;
		gap();
		r = sda_i;
		scl_o = 1'b0;
		gap();
	endtask
	// msb first, then the acknowledge slot
	task automatic byte_io(input logic [7:0] b, input logic ack_in, output logic [7:0] r, output logic ack);
		logic a;
		for (int i = 7; i >= 0; i--) begin
			bit_io(b[i], r[i]);
		end
		bit_io(ack_in, a);
		ack = ~a;
	endtask
	task automatic write2(input logic [7:0] a, input logic [7:0] d0, input logic [7:0] d1,
			input logic two, output logic ok);
		logic [7:0] r;
		logic k1, k2, k3, k4;
		start_cond();
		byte_io({dev_addr, 1'b0}, 1'b1, r, k1);
		byte_io(a, 1'b1, r, k2);
		byte_io(d0, 1'b1, r, k3);
		k4 = 1'b1;
		if (two) begin
			byte_io(d1, 1'b1, r, k4);
		end
		stop_cond();
		ok = k1 & k2 & k3 & k4;
	endtask
	// two bytes read: controller acks the first, refuses the second
	task automatic read2(input logic [7:0] a, output logic [7:0] d0, output logic [7:0] d1, output logic ok);
		logic k1, k2, k3, k4;
		start_cond();
		byte_io({dev_addr, 1'b0}, 1'b1, d0, k1);
		byte_io(a, 1'b1, d0, k2);
		start_cond();
		byte_io({dev_addr, 1'b1}, 1'b1, d0, k3);
		byte_io(8'hFF, 1'b0, d0, k4);
		byte_io(8'hFF, 1'b1, d1, k4);
		stop_cond();
		ok = k1 & k2 & k3;
	endtask
endmodule
`default_nettype wire

// >>> ccs_pkg.sv
// package: register map, reset values and carriers for the charger register bank
`default_nettype none
package ccs_pkg;
	// ---------------------------------------------------------------
	// register offsets
	// ---------------------------------------------------------------
	localparam logic [7:0] CCS_OFF_STATUS = 8'h00;
	localparam logic [7:0] CCS_OFF_CONTROL = 8'h01;
	localparam logic [7:0] CCS_OFF_VOLTAGE = 8'h02;
	localparam logic [7:0] CCS_OFF_IDENT = 8'h03;
	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int CCS_ST_PIN_BIT = 7;
	localparam int CCS_ST_IND_BIT = 6;
	localparam int CCS_CT_EOC_BIT = 3;
	localparam int CCS_CT_DIS_BIT = 2;
	localparam int CCS_CT_HZ_BIT = 1;
	localparam int CCS_CT_OPS_BIT = 0;
	localparam int CCS_VT_CODE_LSB = 2;
	localparam int CCS_VT_POL_BIT = 1;
	localparam int CCS_VT_EN_BIT = 0;
	// ---------------------------------------------------------------
	// reset values and limits
	// ---------------------------------------------------------------
	localparam logic CCS_IND_RST = 1'b1;
	localparam logic [7:0] CCS_CTRL_RST = 8'h30;
	localparam logic [7:0] CCS_VOLT_RST = 8'h0A;
	localparam logic [5:0] CCS_VCODE_MAX = 6'h32;
	localparam logic [6:0] CCS_I2C_ADDR = 7'h6A;
	// ---------------------------------------------------------------
	// carriers
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [1:0] progress;
		logic boost;
		logic [2:0] fault;
	} ccs_chg_t;
	typedef struct packed {
		logic en;
		logic [7:0] addr;
		logic [7:0] data;
	} ccs_wr_t;
	typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_PTR, ST_WRITE, ST_READ, ST_WAIT} ccs_state_t;
endpackage
`default_nettype wire

// >>> ccs_regs.sv
// design: charger control and status register bank behind an i2c target port
//
// Function
// - status bit 7 reads the live level of the boost request pin
// - status bit 6 enables the indicator pin function, resets to enabled
// - status bits 5:4 report ready, charging, complete or fault
// - status bit 3 reads 1 in boost mode, 0 otherwise and after reset
// - status bits 2:0 report the charge fault code
// - control bit 3 enables end-of-charge termination, resets disabled
// - control bit 2 disables the charger when 1, resets to 0
// - control bit 1 requests high-impedance mode when 1, resets to 0
// - control bit 0 selects boost when 1, charger when 0, resets charger
// - voltage bits 7:2 hold the regulation code, high codes saturate, reset 0x0A
// - voltage bit 0 enables host use of the request pin, resets 0
// - polarity bit sets the request pin active level, 1 high, 0 low
// - a boost fault clears the boost select bit
// - leaving high-impedance needs inhibit low, input above lockout, and request bit 0 or an active request pin
// - identification reads maker, part and revision codes, read-only
// - status reads indicator enable 1 and boost 0 after reset
// - control resets to 0x30, upper nibble unassigned
`timescale 1ns/1ps
`default_nettype none
module ccs_regs #(
	parameter logic [6:0] DEV_ADDR = ccs_pkg::CCS_I2C_ADDR,
	// identity values are arbitrary
	parameter logic [2:0] MAKER_CODE = 3'h7,
	parameter logic [1:0] PART_CODE = 2'h1,
	parameter logic [2:0] REV_CODE = 3'h0
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic rst_i,
	// i2c target pins
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	// device pins
	input wire logic boost_req_pin_i,
	input wire logic charge_inhibit_pin_i,
	// charger state
	input wire ccs_pkg::ccs_chg_t chg_state_i,
	input wire logic boost_fault_i,
	input wire logic input_above_uvlo_i,
	// control outputs
	output logic indicator_enable_o,
	output logic end_of_charge_enable_o,
	output logic charger_disable_o,
	output logic high_impedance_request_o,
	output logic high_impedance_mode_o,
	output logic operation_select_o,
	output logic [5:0] charge_voltage_code_o,
	output logic request_pin_polarity_o,
	output logic request_pin_enable_o,
	output logic boost_enable_o
);
	import ccs_pkg::*;

	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------
	localparam int NPIN = 4;
	logic [NPIN-1:0] pin_raw;
	logic [NPIN-1:0] pin_s1;
	logic [NPIN-1:0] pin_s2;
	logic [NPIN-1:0] pin_s3;
	logic [NPIN-1:0] pin_f;
	logic [NPIN-1:0] pin_q;
	assign pin_raw = {charge_inhibit_pin_i, boost_req_pin_i, sda_i, scl_i};

	genvar g;
	generate
		for (g = 0; g < NPIN; g++) begin : g_sync
			always_ff @(posedge clock_i or posedge rst_i) begin
				if (rst_i) begin
					pin_s1[g] <= 1'b1;
					pin_s2[g] <= 1'b1;
					pin_s3[g] <= 1'b1;
					pin_f[g] <= 1'b1;
					pin_q[g] <= 1'b1;
				end else begin
					pin_s1[g] <= pin_raw[g];
					pin_s2[g] <= pin_s1[g];
					pin_s3[g] <= pin_s2[g];
					if (pin_s2[g] == pin_s3[g]) begin
						pin_f[g] <= pin_s3[g];
					end
					pin_q[g] <= pin_f[g];
				end
			end
		end
	endgenerate

	wire scl_f = pin_f[0];
	wire sda_f = pin_f[1];
	wire req_pin_f = pin_f[2];
	wire inhibit_f = pin_f[3];
	wire scl_rise = scl_f & ~pin_q[0];
	wire scl_fall = ~scl_f & pin_q[0];
	wire bus_start = scl_f & pin_q[0] & pin_q[1] & ~sda_f;
	wire bus_stop = scl_f & pin_q[0] & ~pin_q[1] & sda_f;

	// ---------------------------------------------------------------
	// i2c target engine
	// ---------------------------------------------------------------
	ccs_state_t state;
	ccs_state_t next_state;
	logic [3:0] bit_cnt;
	logic [7:0] shift;
	logic [7:0] ptr;
	logic ack_phase;
	logic sda_drive;
	logic rw;
	logic [7:0] rd_byte;
	ccs_wr_t wr;

	wire byte_done = scl_fall & ~ack_phase & (bit_cnt == 4'h8);
	wire addr_hit = (shift[7:1] == DEV_ADDR);
	wire ack_end = scl_fall & ack_phase;
	wire master_ack = scl_rise & ack_phase & (state == ST_READ) & ~sda_f;
	wire master_nack = scl_rise & ack_phase & (state == ST_READ) & sda_f;
	assign wr = '{en: byte_done & (state == ST_WRITE) & ~bus_start & ~bus_stop, addr: ptr, data: shift};

	always_comb begin
		next_state = state;
		if (bus_start) begin
			next_state = ST_ADDR;
		end else if (bus_stop) begin
			next_state = ST_IDLE;
		end else if (master_nack) begin
			next_state = ST_WAIT;
		end else if (byte_done && state == ST_ADDR && !addr_hit) begin
			next_state = ST_WAIT;
		end else if (ack_end) begin
			unique case (state)
				ST_ADDR: next_state = rw ? ST_READ : ST_PTR;
				ST_PTR: next_state = ST_WRITE;
				ST_IDLE, ST_WRITE, ST_READ, ST_WAIT: next_state = state;
			endcase
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			bit_cnt <= 4'h0;
			shift <= 8'h00;
			ack_phase <= 1'b0;
			sda_drive <= 1'b0;
			rw <= 1'b0;
		end else if (bus_start || bus_stop) begin
			bit_cnt <= 4'h0;
			ack_phase <= 1'b0;
			sda_drive <= 1'b0;
		end else if (scl_rise && !ack_phase) begin
			bit_cnt <= bit_cnt + 4'h1;
			if (state != ST_READ) begin
				shift <= {shift[6:0], sda_f};
			end
		end else if (ack_end) begin
			ack_phase <= 1'b0;
			bit_cnt <= 4'h0;
			sda_drive <= 1'b0;
			if (next_state == ST_READ) begin
				shift <= rd_byte;
				sda_drive <= ~rd_byte[7];
			end
		end else if (byte_done) begin
			ack_phase <= (state == ST_READ) || (state != ST_WAIT && state != ST_IDLE &&
				(state != ST_ADDR || addr_hit));
			sda_drive <= (state != ST_READ) && (state != ST_WAIT) && (state != ST_IDLE) &&
				(state != ST_ADDR || addr_hit);
			if (state == ST_ADDR) begin
				rw <= shift[0];
			end
		end else if (scl_fall && state == ST_READ && !ack_phase) begin
			shift <= {shift[6:0], 1'b0};
			sda_drive <= ~shift[6];
		end
	end

	// pointer loads from the second byte and advances per acknowledged byte
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			ptr <= 8'h00;
		end else if (byte_done && state == ST_PTR) begin
			ptr <= shift;
		end else if (wr.en || master_ack) begin
			ptr <= ptr + 8'h01;
		end
	end

	assign sda_o = 1'b0;
	assign sda_oe_o = sda_drive;

	// ---------------------------------------------------------------
	// register storage
	// ---------------------------------------------------------------
	logic ind_en;
	logic [3:0] ctrl;
	logic [7:0] volt;
	wire wr_status = wr.en & (wr.addr == CCS_OFF_STATUS);
	wire wr_control = wr.en & (wr.addr == CCS_OFF_CONTROL);
	wire wr_voltage = wr.en & (wr.addr == CCS_OFF_VOLTAGE);

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			ind_en <= CCS_IND_RST;
		end else if (wr_status) begin
			ind_en <= wr.data[CCS_ST_IND_BIT];
		end
	end

	// only the low nibble is stored, the rest of the byte is dropped
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			ctrl <= CCS_CTRL_RST[3:0];
		end else begin
			if (wr_control) begin
				ctrl <= wr.data[3:0];
			end
			if (boost_fault_i) begin
				ctrl[CCS_CT_OPS_BIT] <= 1'b0;
			end
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			volt <= CCS_VOLT_RST;
		end else if (wr_voltage) begin
			volt <= wr.data;
		end
	end

	// ---------------------------------------------------------------
	// read data
	// ---------------------------------------------------------------
	wire [7:0] status_rd = {req_pin_f, ind_en, chg_state_i.progress, chg_state_i.boost,
		chg_state_i.fault};
	wire [7:0] control_rd = {CCS_CTRL_RST[7:4], ctrl};
	wire [7:0] ident_rd = {MAKER_CODE, PART_CODE, REV_CODE};
	assign rd_byte = (ptr == CCS_OFF_STATUS) ? status_rd :
		(ptr == CCS_OFF_CONTROL) ? control_rd :
		(ptr == CCS_OFF_VOLTAGE) ? volt :
		(ptr == CCS_OFF_IDENT) ? ident_rd : 8'h00;

	// ---------------------------------------------------------------
	// control outputs
	// ---------------------------------------------------------------
	wire [5:0] vcode = volt[7:CCS_VT_CODE_LSB];
	wire req_active = volt[CCS_VT_EN_BIT] & (req_pin_f == volt[CCS_VT_POL_BIT]);
	assign indicator_enable_o = ind_en;
	assign end_of_charge_enable_o = ctrl[CCS_CT_EOC_BIT];
	assign charger_disable_o = ctrl[CCS_CT_DIS_BIT];
	assign high_impedance_request_o = ctrl[CCS_CT_HZ_BIT];
	assign operation_select_o = ctrl[CCS_CT_OPS_BIT];
	assign charge_voltage_code_o = (vcode > CCS_VCODE_MAX) ? CCS_VCODE_MAX : vcode;
	assign request_pin_polarity_o = volt[CCS_VT_POL_BIT];
	assign request_pin_enable_o = volt[CCS_VT_EN_BIT];
	assign boost_enable_o = (ctrl[CCS_CT_OPS_BIT] & ~ctrl[CCS_CT_HZ_BIT]) | req_active;
	assign high_impedance_mode_o = inhibit_f | ~input_above_uvlo_i |
		(ctrl[CCS_CT_HZ_BIT] & ~req_active);

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (rst_i);

	property p_pin_level;
		$past(pin_s2[2]) == $past(pin_s3[2]) |-> req_pin_f == $past(pin_s3[2]) &&
			status_rd[CCS_ST_PIN_BIT] == req_pin_f;
	endproperty
	a_pin_level: assert property (p_pin_level) else $error("status pin bit wrong");

	property p_ind_write;
		wr_status |=> indicator_enable_o == $past(wr.data[CCS_ST_IND_BIT]);
	endproperty
	a_ind_write: assert property (p_ind_write) else $error("indicator enable not written");

	property p_status_live;
		status_rd[5:0] == chg_state_i;
	endproperty
	a_status_live: assert property (p_status_live) else $error("status fields wrong");

	property p_ctrl_write;
		wr_control && !boost_fault_i |=> ctrl == $past(wr.data[3:0]) ##1 ctrl == $past(ctrl) || boost_fault_i
			|| $past(wr_control) || $past(boost_fault_i);
	endproperty
	a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");

	property p_fault_clear;
		boost_fault_i |=> !operation_select_o;
	endproperty
	a_fault_clear: assert property (p_fault_clear) else $error("boost select kept on fault");

	property p_vsat;
		charge_voltage_code_o <= CCS_VCODE_MAX && (vcode <= CCS_VCODE_MAX -> charge_voltage_code_o == vcode);
	endproperty
	a_vsat: assert property (p_vsat) else $error("voltage code not saturated");

	property p_hz_hold;
		inhibit_f || !input_above_uvlo_i |-> high_impedance_mode_o;
	endproperty
	a_hz_hold: assert property (p_hz_hold) else $error("left high impedance too early");

	property p_ctrl_upper;
		control_rd[7:4] == 4'h3 && (ptr != CCS_OFF_CONTROL || rd_byte[7:4] == 4'h3);
	endproperty
	a_ctrl_upper: assert property (p_ctrl_upper) else $error("control upper bits wrong");

	property p_ident_ro;
		wr.en && wr.addr == CCS_OFF_IDENT |=> ident_rd == {MAKER_CODE, PART_CODE, REV_CODE} && ctrl == $past(ctrl)
			|| $past(boost_fault_i);
	endproperty
	a_ident_ro: assert property (p_ident_ro) else $error("identity write had effect");

	property p_req_active;
		volt[CCS_VT_EN_BIT] && req_pin_f == volt[CCS_VT_POL_BIT] |-> boost_enable_o;
	endproperty
	a_req_active: assert property (p_req_active) else $error("request pin did not enable boost");

	property p_boost_sel;
		operation_select_o && !high_impedance_request_o |-> boost_enable_o;
	endproperty
	a_boost_sel: assert property (p_boost_sel) else $error("boost select did not enable boost");

	property p_ack_drive;
		byte_done && state == ST_ADDR && addr_hit |=> sda_oe_o && ack_phase;
	endproperty
	a_ack_drive: assert property (p_ack_drive) else $error("address not acknowledged");
endmodule
`default_nettype wire

// >>> test_charger_control_status_regs.sv
// testbench: register bank driven over its i2c target port
`timescale 1ns/1ps
`default_nettype none
module test_charger_control_status_regs;
	import ccs_pkg::*;
	// -----------------------------------------------------------
	// signals, clock and open drain data line
	// -----------------------------------------------------------
	logic clock_i = 1'b0;
	logic rst_i = 1'b1;
	logic scl, host_low, sda_oe, sda_out, ok;
	logic pin = 1'b0, inhibit = 1'b0, bfault = 1'b0, uvlo = 1'b1;
	ccs_chg_t chg = '0;
	logic ind, eoc, dis, hzr, hzm, ops, pol, pen, ben;
	logic [5:0] vcode;
	logic [7:0] d0, d1;
	int failures = 0;
	int checks_done = 0;
	wire logic sda = !((sda_oe && !sda_out) || host_low);
	always #25 clock_i = ~clock_i;
	// identity values are arbitrary
	ccs_regs #(.MAKER_CODE(3'h5), .PART_CODE(2'h3), .REV_CODE(3'h6)) i_ccs_regs (.clock_i(clock_i),
		.rst_i(rst_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_out), .sda_oe_o(sda_oe),
		.boost_req_pin_i(pin), .charge_inhibit_pin_i(inhibit), .chg_state_i(chg), .boost_fault_i(bfault),
		.input_above_uvlo_i(uvlo), .indicator_enable_o(ind), .end_of_charge_enable_o(eoc),
		.charger_disable_o(dis), .high_impedance_request_o(hzr), .high_impedance_mode_o(hzm),
		.operation_select_o(ops), .charge_voltage_code_o(vcode), .request_pin_polarity_o(pol),
		.request_pin_enable_o(pen), .boost_enable_o(ben));
	ccs_host_model i_ccs_host_model (.clock_i(clock_i), .sda_i(sda), .scl_o(scl), .sda_low_o(host_low));
	// -----------------------------------------------------------
	// compare and closing tasks
	// -----------------------------------------------------------
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("BAD %0t byte got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("BAD %0t bit got %b expected %b", $time, got, exp);
		end
	endtask
	task automatic settle();
		repeat (8) @(negedge clock_i);
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		repeat (60000) @(posedge clock_i);
		failures++;
		finish_test();
	end
	// -----------------------------------------------------------
	// tests
	// -----------------------------------------------------------
	initial begin
		repeat (6) @(negedge clock_i);
		rst_i = 1'b0;
		settle();
		chk_bit(ind, 1'b1);
		chk_byte({4'h0, eoc, dis, hzr, ops}, 8'h00);
		chk_byte({vcode, pol, pen}, 8'h0A);
		i_ccs_host_model.read2(CCS_OFF_CONTROL, d0, d1, ok);
		chk_bit(ok, 1'b1);
		chk_byte(d0, 8'h30);
		chk_byte(d1, 8'h0A);
		$display("test reset values done");
		for (int i = 0; i < 8; i++) begin
			pin = i[1];
			chg = ccs_chg_t'({i[1:0], i[0], i[2:0]});
			i_ccs_host_model.read2(CCS_OFF_STATUS, d0, d1, ok);
			chk_byte(d0, {i[1], 1'b1, i[1:0], i[0], i[2:0]});
		end
		pin = 1'b0;
		chg = '0;
		$display("test status codes done");
		i_ccs_host_model.write2(CCS_OFF_STATUS, 8'h00, 8'hFF, 1'b1, ok);
		chk_bit(ok, 1'b1);
		settle();
		chk_bit(ind, 1'b0);
		chk_byte({4'h0, eoc, dis, hzr, ops}, 8'h0F);
		chk_bit(hzm, 1'b1);
		i_ccs_host_model.read2(CCS_OFF_STATUS, d0, d1, ok);
		chk_byte(d0, 8'h00);
		chk_byte(d1, 8'h3F);
		i_ccs_host_model.write2(CCS_OFF_CONTROL, 8'h01, 8'h00, 1'b0, ok);
		settle();
		chk_bit(hzm, 1'b0);
		chk_bit(ben, 1'b1);
		inhibit = 1'b1;
		settle();
		chk_bit(hzm, 1'b1);
		inhibit = 1'b0;
		uvlo = 1'b0;
		settle();
		chk_bit(hzm, 1'b1);
		uvlo = 1'b1;
		bfault = 1'b1;
		@(negedge clock_i);
		bfault = 1'b0;
		settle();
		chk_bit(ops, 1'b0);
		i_ccs_host_model.read2(CCS_OFF_CONTROL, d0, d1, ok);
		chk_byte(d0, 8'h30);
		$display("test control bits done");
		i_ccs_host_model.write2(CCS_OFF_VOLTAGE, 8'hCB, 8'h00, 1'b1, ok);
		settle();
		chk_byte({vcode, pol, pen}, 8'hCB);
		pin = 1'b1;
		settle();
		chk_bit(ben, 1'b1);
		pin = 1'b0;
		settle();
		chk_bit(ben, 1'b0);
		i_ccs_host_model.read2(CCS_OFF_IDENT, d0, d1, ok);
		chk_byte(d0, 8'hBE);
		chk_byte(d1, 8'h00);
		i_ccs_host_model.write2(CCS_OFF_VOLTAGE, 8'hFD, 8'h00, 1'b0, ok);
		settle();
		chk_byte({vcode, pol, pen}, {6'h32, 2'b01});
		chk_bit(ben, 1'b1);
		i_ccs_host_model.read2(CCS_OFF_VOLTAGE, d0, d1, ok);
		chk_byte(d0, 8'hFD);
		$display("test voltage and identity done");
		i_ccs_host_model.dev_addr = 7'h6B;
		i_ccs_host_model.write2(CCS_OFF_CONTROL, 8'h0F, 8'h00, 1'b0, ok);
		i_ccs_host_model.dev_addr = CCS_I2C_ADDR;
		settle();
		chk_bit(ok, 1'b0);
		chk_byte({4'h0, eoc, dis, hzr, ops}, 8'h00);
		$display("test foreign address done");
		i_ccs_host_model.write2(CCS_OFF_CONTROL, 8'h0C, 8'h00, 1'b0, ok);
		settle();
		chk_byte({4'h0, eoc, dis, hzr, ops}, 8'h0C);
		rst_i = 1'b1;
		repeat (2) @(negedge clock_i);
		rst_i = 1'b0;
		settle();
		chk_bit(ind, 1'b1);
		chk_byte({4'h0, eoc, dis, hzr, ops}, 8'h00);
		chk_byte({vcode, pol, pen}, 8'h0A);
		i_ccs_host_model.read2(CCS_OFF_CONTROL, d0, d1, ok);
		chk_byte(d0, 8'h30);
		$display("test second reset done");
		finish_test();
	end
endmodule
`default_nettype wire
